// [verilog/fcs_flash_command_sequencer.sv]
`timescale 1ns/1ps
`include "fcs_map.svh"
module fcs_flash_command_sequencer (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Host array writes
  input  wire logic        arr_wr_in,
  input  wire logic [15:0] arr_wr_addr_in,
  input  wire logic [15:0] arr_wr_data_in,
  input  wire logic        arr_wr_byte_in,
  // Host array reads
  input  wire logic [15:0] arr_rd_addr_in,
  output logic      [15:0] rd_data_out,
  // Host register writes
  input  wire logic        clkdiv_wr_in,
  input  wire logic [6:0]  clkdiv_data_in,
  input  wire logic        cmd_wr_in,
  input  wire logic [7:0]  cmd_data_in,
  input  wire logic        stat_wr_in,
  input  wire logic [7:0]  stat_data_in,
  input  wire logic        prot_wr_in,
  input  wire logic [7:0]  prot_data_in,
  input  wire logic        other_reg_wr_in,
  // Interrupt enables
  input  wire logic        buffer_empty_int_en_in,
  input  wire logic        complete_int_en_in,
  // Operating mode
  input  wire logic        stop_mode_in,
  input  wire logic        background_debug_mode_in,
  input  wire logic        nonsecure_src_in,
  // Status
  output logic             buffer_empty_flag_out,
  output logic             command_complete_flag_out,
  output logic             protection_violation_flag_out,
  output logic             access_error_flag_out,
  output logic             blank_flag_out,
  output logic             divider_loaded_flag_out,
  output logic      [6:0]  clock_divider_reg_out,
  output logic      [7:0]  protection_reg_out,
  output logic             secure_out,
  output logic             reset_busy_out,
  output logic             irq_out,
  // Array macro
  output logic      [15:0] arr_raddr_out,
  input  wire logic [15:0] arr_rdata_in,
  output logic      [1:0]  arr_op_out,
  output logic      [15:0] arr_addr_out,
  output logic      [15:0] arr_data_out,
  output logic             hv_en_out
);

  // ==========================================================
  // State
  fcs_pkg::fcs_seq_t seq_r;
  fcs_pkg::fcs_eng_t eng_r;
  logic [15:0] wr_addr_r;
  logic [15:0] wr_data_r;
  logic [7:0]  wr_cmd_r;
  logic        buf_valid_r;
  logic [15:0] buf_addr_r;
  logic [15:0] buf_data_r;
  logic [7:0]  buf_cmd_r;
  logic [15:0] ev_addr_r;
  logic [15:0] tick_cnt_r;
  logic        stop_r;
  logic        prot_wr_done_r;
  logic        tick;

  // ==========================================================
  // Decode
  wire seq_idle = (seq_r == fcs_pkg::SEQ_IDLE);
  wire seq_word = (seq_r == fcs_pkg::SEQ_WORD);
  wire seq_cmd  = (seq_r == fcs_pkg::SEQ_CMD);
  wire eng_idle = (eng_r == fcs_pkg::ENG_IDLE);
  wire eng_run  = (eng_r == fcs_pkg::ENG_RUN);
  wire eng_ver  = (eng_r == fcs_pkg::ENG_VERIFY);
  wire eng_sec  = (eng_r == fcs_pkg::ENG_SEC);
  wire locked   = access_error_flag_out | protection_violation_flag_out;
  wire other_wr = other_reg_wr_in | clkdiv_wr_in | prot_wr_in;
  wire stop_enter = stop_mode_in & !stop_r;
  wire stop_exit  = !stop_mode_in & stop_r;

  wire aw_err = arr_wr_in & (!divider_loaded_flag_out | arr_wr_byte_in |
                arr_wr_addr_in[0] | !buffer_empty_flag_out | !seq_idle);
  wire aw_ok  = arr_wr_in & !aw_err;

  wire cmd_known = (cmd_data_in == `FCS_CMD_ERASE_VERIFY) |
                   (cmd_data_in == `FCS_CMD_PROGRAM) |
                   (cmd_data_in == `FCS_CMD_SECTOR_ERASE) |
                   (cmd_data_in == `FCS_CMD_MASS_ERASE);
  // secured part restricted to mass erase from a nonsecure source or in debug
  wire cmd_sec_bad = secure_out & (cmd_data_in != `FCS_CMD_MASS_ERASE) &
                     (nonsecure_src_in | background_debug_mode_in);
  // command only directly after the word
  wire cw_err = cmd_wr_in & (!seq_word | !cmd_known | cmd_sec_bad);
  wire cw_ok  = cmd_wr_in & !cw_err;
  wire ow_err = other_wr & !seq_idle;
  wire st_cbe = stat_data_in[`FCS_STAT_BUFFER_EMPTY_FLAG];
  // status write after word, or zero to buffer-empty after command
  wire st_err = stat_wr_in & (seq_word | (seq_cmd & !st_cbe));
  wire launch_req = stat_wr_in & st_cbe & seq_cmd;

  // ==========================================================
  // Protection check
  wire [15:0] hi_bound = 16'(`FCS_TOP_PLUS1 -
                  (`FCS_HI_UNIT << protection_reg_out[`FCS_PROT_HI_SZ]));
  wire [15:0] lo_top = 16'(`FCS_ARRAY_BASE +
                  (`FCS_LO_UNIT << protection_reg_out[`FCS_PROT_LO_SZ]));
  wire        p_open  = protection_reg_out[`FCS_PROT_OPEN];
  wire        p_hidis = protection_reg_out[`FCS_PROT_HI_DIS];
  wire        p_lodis = protection_reg_out[`FCS_PROT_LO_DIS];
  wire [15:0] sect_base = wr_addr_r & `FCS_SECTOR_MASK;
  wire prog_hit = !p_open | (!p_hidis & (wr_addr_r >= hi_bound)) |
                  (!p_lodis & (wr_addr_r < lo_top));
  wire sect_hit = !p_open | (!p_hidis & (sect_base >= hi_bound)) |
                  (!p_lodis & (sect_base < lo_top));
  wire mass_hit = !p_open | !p_hidis | !p_lodis;
  wire prot_hit = ((wr_cmd_r == `FCS_CMD_PROGRAM) & prog_hit) |
                  ((wr_cmd_r == `FCS_CMD_SECTOR_ERASE) & sect_hit) |
                  ((wr_cmd_r == `FCS_CMD_MASS_ERASE) & mass_hit);

  // launch refused while an error flag stands
  wire launch_ok = launch_req & !locked & !prot_hit & !stop_mode_in;
  wire protection_violation_flag_set = launch_req & !locked & prot_hit;
  wire stop_abort = stop_enter & !command_complete_flag_out;
  wire acc_set = aw_err | cw_err | ow_err | st_err | stop_abort;

  // ==========================================================
  // Engine decode
  wire start = buf_valid_r & eng_idle & !stop_mode_in;
  wire ev_bad  = eng_ver & (arr_rdata_in != `FCS_ERASED_WORD);
  wire ev_last = eng_ver & (ev_addr_r == `FCS_ARRAY_LAST);
  wire run_end = eng_run & tick & (tick_cnt_r == 16'h0001);
  wire done    = run_end | ev_bad | ev_last;
  wire [15:0] op_ticks =
      (buf_cmd_r == `FCS_CMD_PROGRAM)      ? `FCS_PROG_TICKS :
      (buf_cmd_r == `FCS_CMD_SECTOR_ERASE) ? `FCS_SERASE_TICKS :
                                             `FCS_MERASE_TICKS;
  wire [1:0] op_code =
      (buf_cmd_r == `FCS_CMD_PROGRAM)      ? fcs_pkg::OP_PROG :
      (buf_cmd_r == `FCS_CMD_SECTOR_ERASE) ? fcs_pkg::OP_SERASE :
                                             fcs_pkg::OP_MERASE;
  // sector erase drops [9:0], mass erase ignores address
  wire [15:0] op_addr =
      (buf_cmd_r == `FCS_CMD_PROGRAM)      ? buf_addr_r :
      (buf_cmd_r == `FCS_CMD_SECTOR_ERASE) ? (buf_addr_r &
                                              `FCS_SECTOR_MASK) :
                                             16'h0000;
  wire [15:0] raddr_nxt = eng_sec ? `FCS_SEC_WORD :
                          eng_ver ? ev_addr_r : arr_rd_addr_in;

  assign irq_out = (buffer_empty_flag_out & buffer_empty_int_en_in) |
                   (command_complete_flag_out & complete_int_en_in);
  assign reset_busy_out = eng_sec;
  assign arr_raddr_out  = raddr_nxt;

  fcs_tick_div u_tick (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .fdiv_in  (clock_divider_reg_out[`FCS_DIV_FDIV]),
    .pre8_in  (clock_divider_reg_out[`FCS_DIV_PRE8]),
    .run_in   (eng_run),
    .tick_out (tick)
  );

  // ==========================================================
  // Command write sequence
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      seq_r     <= fcs_pkg::SEQ_IDLE;
      wr_addr_r <= 16'h0000;
      wr_data_r <= 16'h0000;
      wr_cmd_r  <= 8'h00;
    end else begin
      // any error or stop returns to idle
      if (acc_set | launch_req | stop_mode_in) begin
        seq_r <= fcs_pkg::SEQ_IDLE;
      end else if (aw_ok) begin
        seq_r <= fcs_pkg::SEQ_WORD;
      end else if (cw_ok) begin
        seq_r <= fcs_pkg::SEQ_CMD;
      end
      if (aw_ok) begin
        wr_addr_r <= arr_wr_addr_in;
        wr_data_r <= arr_wr_data_in;
      end
      if (cw_ok) begin
        wr_cmd_r <= cmd_data_in;
      end
    end
  end

  // ==========================================================
  // Buffer stage
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      buf_valid_r <= 1'b0;
      buf_addr_r  <= 16'h0000;
      buf_data_r  <= 16'h0000;
      buf_cmd_r   <= 8'h00;
    end else begin
      // stop discards; buffered waits for engine
      if (stop_abort | stop_exit) begin
        buf_valid_r <= 1'b0;
      end else if (launch_ok) begin
        buf_valid_r <= 1'b1;
        buf_addr_r  <= wr_addr_r;
        buf_data_r  <= wr_data_r;
        buf_cmd_r   <= wr_cmd_r;
      end else if (start) begin
        buf_valid_r <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Flags
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      buffer_empty_flag_out         <= 1'b1;
      command_complete_flag_out     <= 1'b1;
      access_error_flag_out         <= 1'b0;
      protection_violation_flag_out <= 1'b0;
      stop_r                        <= 1'b0;
    end else begin
      stop_r <= stop_mode_in;
      // launch clears buffer-empty until moved to engine
      if (stop_exit | start) begin
        buffer_empty_flag_out <= 1'b1;
      end else if (launch_ok) begin
        buffer_empty_flag_out <= 1'b0;
      end
      // complete only when nothing remains buffered
      if (stop_abort | (done & !buf_valid_r & !launch_ok)) begin
        command_complete_flag_out <= 1'b1;
      end else if (launch_ok) begin
        command_complete_flag_out <= 1'b0;
      end
      // Set wins over a same-cycle software clear
      if (acc_set) begin
        access_error_flag_out <= 1'b1;
      end else if (stat_wr_in & stat_data_in[`FCS_STAT_ACCESS_ERROR_FLAG]) begin
        access_error_flag_out <= 1'b0;
      end
      if (protection_violation_flag_set) begin
        protection_violation_flag_out <= 1'b1;
      end else if (stat_wr_in & stat_data_in[`FCS_STAT_PROTECTION_VIOLATION_FLAG]) begin
        protection_violation_flag_out <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Configuration registers
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      clock_divider_reg_out   <= 7'h00;
      divider_loaded_flag_out <= 1'b0;
      protection_reg_out      <= `FCS_PROT_RESET;
      prot_wr_done_r          <= 1'b0;
    end else begin
      if (clkdiv_wr_in) begin
        clock_divider_reg_out   <= clkdiv_data_in;
        divider_loaded_flag_out <= 1'b1;
      end
      // writable once normally, always in debug
      if (prot_wr_in & (background_debug_mode_in | !prot_wr_done_r)) begin
        protection_reg_out <= prot_data_in;
        prot_wr_done_r     <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Algorithm engine
  // wait mode has no effect, so work runs to the end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      eng_r          <= fcs_pkg::ENG_SEC;
      secure_out     <= 1'b1;
      blank_flag_out <= 1'b0;
      ev_addr_r      <= `FCS_ARRAY_BASE;
      tick_cnt_r     <= 16'h0000;
      arr_op_out     <= fcs_pkg::OP_NONE;
      arr_addr_out   <= 16'h0000;
      arr_data_out   <= 16'h0000;
      hv_en_out      <= 1'b0;
    end else if (stop_enter) begin
      if (!eng_sec) begin
        eng_r <= fcs_pkg::ENG_IDLE;
      end
      arr_op_out <= fcs_pkg::OP_NONE;
      hv_en_out  <= 1'b0;
    end else begin
      unique case (eng_r)
        fcs_pkg::ENG_SEC: begin
          // security byte sampled after every reset
          secure_out <= (arr_rdata_in[1:0] != `FCS_SEC_UNSECURE);
          eng_r      <= fcs_pkg::ENG_IDLE;
        end
        fcs_pkg::ENG_IDLE: begin
          if (start && buf_cmd_r == `FCS_CMD_ERASE_VERIFY) begin
            // whole array, address and data ignored
            blank_flag_out <= 1'b0;
            ev_addr_r      <= `FCS_ARRAY_BASE;
            eng_r          <= fcs_pkg::ENG_VERIFY;
          end else if (start) begin
            tick_cnt_r   <= op_ticks;
            arr_op_out   <= op_code;
            arr_addr_out <= op_addr;
            arr_data_out <= buf_data_r;
            hv_en_out    <= 1'b1;
            eng_r        <= fcs_pkg::ENG_RUN;
          end
        end
        fcs_pkg::ENG_RUN: begin
          if (run_end) begin
            arr_op_out <= fcs_pkg::OP_NONE;
            hv_en_out  <= 1'b0;
            eng_r      <= fcs_pkg::ENG_IDLE;
          end else if (tick) begin
            tick_cnt_r <= tick_cnt_r - 16'h0001;
          end
        end
        fcs_pkg::ENG_VERIFY: begin
          if (ev_bad) begin
            eng_r <= fcs_pkg::ENG_IDLE;
          end else if (ev_last) begin
            blank_flag_out <= 1'b1;
            eng_r          <= fcs_pkg::ENG_IDLE;
          end else begin
            ev_addr_r <= ev_addr_r + 16'h0002;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // Host read data
  // reads raise no error; invalid while algorithm runs
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= `FCS_INVALID_DATA;
    end else if (command_complete_flag_out & !eng_sec) begin
      rd_data_out <= arr_rdata_in;
    end else begin
      rd_data_out <= `FCS_INVALID_DATA;
    end
  end

endmodule

// [verilog/fcs_map.svh]
`ifndef FCS_MAP_SVH
`define FCS_MAP_SVH

// ==========================================================
// Command codes
`define FCS_CMD_ERASE_VERIFY 8'h05
`define FCS_CMD_PROGRAM      8'h20
`define FCS_CMD_SECTOR_ERASE 8'h40
`define FCS_CMD_MASS_ERASE   8'h41

// ==========================================================
// Array map; the security byte is the low byte of its word
`define FCS_ARRAY_BASE   16'h4000
`define FCS_ARRAY_LAST   16'hfffe
`define FCS_SEC_WORD     16'hff0e
`define FCS_SEC_UNSECURE 2'b10
`define FCS_SECTOR_MASK  16'hfc00
`define FCS_ERASED_WORD  16'hffff
`define FCS_INVALID_DATA 16'h0000
`define FCS_HI_UNIT      17'h00800
`define FCS_LO_UNIT      16'h0400
`define FCS_TOP_PLUS1    17'h10000

// ==========================================================
// Status write bit positions
`define FCS_STAT_BUFFER_EMPTY_FLAG  7
`define FCS_STAT_PROTECTION_VIOLATION_FLAG  5
`define FCS_STAT_ACCESS_ERROR_FLAG 4

// ==========================================================
// Protection register fields and reset value
`define FCS_PROT_OPEN   7
`define FCS_PROT_HI_DIS 5
`define FCS_PROT_HI_SZ  4:3
`define FCS_PROT_LO_DIS 2
`define FCS_PROT_LO_SZ  1:0
`define FCS_PROT_RESET  8'hff

// ==========================================================
// Divider fields and algorithm lengths in timing ticks
`define FCS_DIV_PRE8    6
`define FCS_DIV_FDIV    5:0
`define FCS_PROG_TICKS  16'h0006
`define FCS_SERASE_TICKS 16'h0fa0
`define FCS_MERASE_TICKS 16'h4e20

`endif

// [verilog/fcs_pkg.sv]
package fcs_pkg;

  typedef enum logic [2:0] {
    SEQ_IDLE = 3'b001,
    SEQ_WORD = 3'b010,
    SEQ_CMD  = 3'b100
  } fcs_seq_t;

  typedef enum logic [3:0] {
    ENG_SEC    = 4'b0001,
    ENG_IDLE   = 4'b0010,
    ENG_RUN    = 4'b0100,
    ENG_VERIFY = 4'b1000
  } fcs_eng_t;

  typedef enum logic [1:0] {
    OP_NONE   = 2'h0,
    OP_PROG   = 2'h1,
    OP_SERASE = 2'h2,
    OP_MERASE = 2'h3
  } fcs_op_t;

endpackage

// [verilog/fcs_tick_div.sv]
`timescale 1ns/1ps
module fcs_tick_div (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Divider setting
  input  wire logic [5:0] fdiv_in,
  input  wire logic       pre8_in,
  input  wire logic       run_in,
  // Timing tick
  output logic            tick_out
);

  logic [2:0] pre_r;
  logic [5:0] cnt_r;
  wire        pre_wrap = !pre8_in || (pre_r == 3'h7);
  wire        cnt_wrap = (cnt_r == fdiv_in);

  // Tick period is (fdiv+1) bus cycles, eight times longer with pre8
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pre_r    <= 3'h0;
      cnt_r    <= 6'h00;
      tick_out <= 1'b0;
    end else if (!run_in) begin
      pre_r    <= 3'h0;
      cnt_r    <= 6'h00;
      tick_out <= 1'b0;
    end else begin
      pre_r    <= pre_wrap ? 3'h0 : pre_r + 3'h1;
      tick_out <= pre_wrap && cnt_wrap;
      if (pre_wrap) begin
        cnt_r <= cnt_wrap ? 6'h00 : cnt_r + 6'h01;
      end
    end
  end

endmodule

// [tb/fcs_array_model.sv]
`timescale 1ns/1ps
// ==========
// Flash array; an operation lands whole as the engine starts it
module fcs_array_model (
  input  wire logic        clk_in,
  input  wire logic [15:0] raddr_in,
  input  wire logic [1:0]  op_in,
  input  wire logic [15:0] addr_in,
  input  wire logic [15:0] data_in,
  output logic      [15:0] rdata_out
);
  logic [15:0] mem [0:32767];
  logic [1:0]  op_q;
  logic [15:0] a_q;
  int          i;
  assign rdata_out = mem[raddr_in[15:1]];
  initial begin
    op_q = 2'h0;
    a_q = 16'h0000;
    for (i = 0; i < 32768; i++)
      mem[i] = 16'hffff;
    mem[15'h7f87] = 16'hfffe;
  end
  always @(posedge clk_in) begin
    op_q <= op_in;
    a_q <= addr_in;
    if (op_in != 2'h0 && (op_in != op_q || addr_in != a_q)) begin
      if (op_in == 2'h1)
        mem[addr_in[15:1]] &= data_in;
      else
        for (i = 8192; i < 32768; i++)
          if (op_in == 2'h3 || i[14:9] == addr_in[15:10])
            mem[i] = 16'hffff;
    end
  end
endmodule

// [tb/fcs_seq_monitor.sv]
`timescale 1ns/1ps
// ==========
// Port checks
module fcs_seq_monitor (
  input wire logic        clk_in,
  input wire logic        rst_in,
  input wire logic        arr_wr_in,
  input wire logic        arr_wr_byte_in,
  input wire logic        cmd_wr_in,
  input wire logic [7:0]  cmd_data_in,
  input wire logic        stat_wr_in,
  input wire logic [7:0]  stat_data_in,
  input wire logic        stop_mode_in,
  input wire logic        background_debug_mode_in,
  input wire logic        buffer_empty_flag_out,
  input wire logic        command_complete_flag_out,
  input wire logic        access_error_flag_out,
  input wire logic        secure_out,
  input wire logic [1:0]  arr_op_out,
  input wire logic        hv_en_out,
  input wire logic [15:0] rd_data_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  byte_err_a: assert property (arr_wr_in && arr_wr_byte_in |=>
    access_error_flag_out) else $error("byte write not refused");
  bad_code_a: assert property (cmd_wr_in &&
    !(cmd_data_in inside {8'h05, 8'h20, 8'h40, 8'h41}) |=>
    access_error_flag_out) else $error("bad code not refused");
  secure_cmd_a: assert property (cmd_wr_in && secure_out &&
    background_debug_mode_in && cmd_data_in != 8'h41 |=>
    access_error_flag_out) else $error("secured command accepted");
  launch_clear_a: assert property ($fell(command_complete_flag_out)
    |-> $past(stat_wr_in) && $past(stat_data_in) >= 8'h80)
    else $error("complete fell without launch");
  lock_out_a: assert property (access_error_flag_out &&
    command_complete_flag_out && stat_wr_in && stat_data_in == 8'h80
    |=> command_complete_flag_out) else $error("launch while locked");
  stop_abort_a: assert property ($rose(stop_mode_in) &&
    !command_complete_flag_out |-> ##[1:2] (arr_op_out == 2'h0 &&
    !hv_en_out && command_complete_flag_out && access_error_flag_out))
    else $error("stop did not abort");
  stop_exit_a: assert property ($fell(stop_mode_in) |->
    ##[1:2] buffer_empty_flag_out) else $error("no buffer empty on exit");
  busy_read_a: assert property (!command_complete_flag_out |=>
    rd_data_out == 16'h0000) else $error("busy read not invalid");
endmodule
bind fcs_flash_command_sequencer fcs_seq_monitor fcs_seq_monitor_inst (
  .clk_in, .rst_in, .arr_wr_in, .arr_wr_byte_in, .cmd_wr_in, .cmd_data_in,
  .stat_wr_in, .stat_data_in, .stop_mode_in, .background_debug_mode_in,
  .buffer_empty_flag_out, .command_complete_flag_out, .access_error_flag_out,
  .secure_out, .arr_op_out, .hv_en_out, .rd_data_out
);

// [tb/test_flash_command_sequencer.sv]
`timescale 1ns/1ps
module test_flash_command_sequencer;
  logic        clk_in, rst_in, arr_wr_in, arr_wr_byte_in, clkdiv_wr_in;
  logic        cmd_wr_in, stat_wr_in, prot_wr_in, other_reg_wr_in;
  logic        buffer_empty_int_en_in, complete_int_en_in, stop_mode_in;
  logic        background_debug_mode_in, nonsecure_src_in, irq_out;
  logic        buffer_empty_flag_out, command_complete_flag_out;
  logic        protection_violation_flag_out, access_error_flag_out;
  logic        blank_flag_out, divider_loaded_flag_out, secure_out;
  logic        reset_busy_out, hv_en_out;
  logic [1:0]  arr_op_out;
  logic [6:0]  clkdiv_data_in, clock_divider_reg_out;
  logic [7:0]  cmd_data_in, stat_data_in, prot_data_in, protection_reg_out;
  logic [15:0] arr_wr_addr_in, arr_wr_data_in, arr_rd_addr_in, rd_data_out;
  logic [15:0] arr_raddr_out, arr_rdata_in, arr_addr_out, arr_data_out;
  int          n_fail, n_checks;
  fcs_flash_command_sequencer fcs_flash_command_sequencer_inst (
    .clk_in, .rst_in, .arr_wr_in, .arr_wr_addr_in, .arr_wr_data_in,
    .arr_wr_byte_in, .arr_rd_addr_in, .rd_data_out, .clkdiv_wr_in,
    .clkdiv_data_in, .cmd_wr_in, .cmd_data_in, .stat_wr_in, .stat_data_in,
    .prot_wr_in, .prot_data_in, .other_reg_wr_in, .buffer_empty_int_en_in,
    .complete_int_en_in, .stop_mode_in, .background_debug_mode_in,
    .nonsecure_src_in, .buffer_empty_flag_out, .command_complete_flag_out,
    .protection_violation_flag_out, .access_error_flag_out, .blank_flag_out,
    .divider_loaded_flag_out, .clock_divider_reg_out, .protection_reg_out,
    .secure_out, .reset_busy_out, .irq_out, .arr_raddr_out, .arr_rdata_in,
    .arr_op_out, .arr_addr_out, .arr_data_out, .hv_en_out
  );
  fcs_array_model fcs_array_model_inst (
    .clk_in, .raddr_in(arr_raddr_out), .op_in(arr_op_out),
    .addr_in(arr_addr_out), .data_in(arr_data_out), .rdata_out(arr_rdata_in)
  );
  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end
  // ==========
  // Helpers
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_fail++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic step;
    @(posedge clk_in);
    #1;
  endtask
  task automatic do_reset;
    rst_in = 1'b1;
    repeat (8) step;
    chk(reset_busy_out, 1'b1);
    rst_in = 1'b0;
    repeat (2) step;
  endtask
  // One register or array write; k picks the strobe
  task automatic wr(input int k, input logic [15:0] a, input logic [15:0] d);
    step;
    arr_wr_addr_in = a;
    arr_wr_data_in = d;
    {cmd_data_in, stat_data_in, prot_data_in} = {3{d[7:0]}};
    clkdiv_data_in = d[6:0];
    {arr_wr_in, cmd_wr_in, stat_wr_in} = {k == 0, k == 1, k == 2};
    {prot_wr_in, clkdiv_wr_in, other_reg_wr_in} = {k == 3, k == 4, k == 5};
    step;
    {arr_wr_in, cmd_wr_in, stat_wr_in} = 3'h0;
    {prot_wr_in, clkdiv_wr_in, other_reg_wr_in} = 3'h0;
  endtask
  task automatic seq(input logic [15:0] a, d, input logic [7:0] c);
    wr(0, a, d);
    wr(1, 16'h0000, {8'h00, c});
    wr(2, 16'h0000, 16'h0080);
  endtask
  task automatic wt(input logic be, input int lim);
    for (int n = 0; n < lim; n++) begin
      if ((be ? buffer_empty_flag_out : command_complete_flag_out) === 1'b1)
        return;
      step;
    end
    chk(16'h0000, 16'h0001);
    results;
  endtask
  task automatic rd(input logic [15:0] a, input logic [15:0] exp);
    arr_rd_addr_in = a;
    step;
    chk(rd_data_out, exp);
  endtask
  // Word, optional command, then the offending write
  task automatic bad(input logic c, input int k, input logic [15:0] d);
    wr(0, 16'h4000, 16'h0000);
    if (c)
      wr(1, 16'h0000, 16'h0020);
    wr(k, 16'h4002, d);
    chk(access_error_flag_out, 1'b1);
    wr(2, 16'h0000, 16'h0030);
  endtask
  task automatic pv(input logic [15:0] a, input logic [7:0] c);
    seq(a, 16'h0000, c);
    chk(protection_violation_flag_out, 1'b1);
    chk(command_complete_flag_out, 1'b1);
    wr(2, 16'h0000, 16'h0020);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset;
    chk(buffer_empty_flag_out, 1'b1);
    chk(command_complete_flag_out, 1'b1);
    chk(protection_reg_out, 8'hff);
    chk(secure_out, 1'b0);
    chk(reset_busy_out, 1'b0);
    chk(divider_loaded_flag_out, 1'b0);
    wr(0, 16'h4000, 16'h0000);
    chk(access_error_flag_out, 1'b1);
    wr(2, 16'h0000, 16'h0030);
    wr(4, 16'h0000, 16'h0000);
    chk(divider_loaded_flag_out, 1'b1);
    complete_int_en_in = 1'b1;
    step;
    chk(irq_out, 1'b1);
    {complete_int_en_in, buffer_empty_int_en_in} = 2'h1;
    step;
    chk(irq_out, 1'b1);
    buffer_empty_int_en_in = 1'b0;
    step;
    chk(irq_out, 1'b0);
  endtask
  task automatic t_program;
    wr(4, 16'h0000, 16'h0040);
    chk(clock_divider_reg_out, 7'h40);
    seq(16'h4002, 16'h1234, 8'h20);
    chk(command_complete_flag_out, 1'b0);
    wt(1'b1, 20);
    chk(arr_op_out, 2'h1);
    chk(arr_data_out, 16'h1234);
    seq(16'h4400, 16'h00f0, 8'h20);
    rd(16'h4002, 16'h0000);
    chk(access_error_flag_out, 1'b0);
    wt(1'b0, 500);
    rd(16'h4002, 16'h1234);
    rd(16'h4400, 16'h00f0);
    wr(4, 16'h0000, 16'h0000);
  endtask
  task automatic t_errors;
    arr_wr_byte_in = 1'b1;
    bad(1'b0, 5, 16'h0000);
    arr_wr_byte_in = 1'b0;
    bad(1'b0, 0, 16'h0000);
    bad(1'b0, 5, 16'h0000);
    bad(1'b0, 1, 16'h0033);
    bad(1'b1, 1, 16'h0020);
    bad(1'b1, 4, 16'h0000);
    bad(1'b1, 2, 16'h0000);
    wr(0, 16'h4001, 16'h0000);
    seq(16'h4006, 16'h0000, 8'h20);
    chk(command_complete_flag_out, 1'b1);
    chk(access_error_flag_out, 1'b1);
    wr(2, 16'h0000, 16'h0030);
  endtask
  task automatic t_protect;
    wr(3, 16'h0000, 16'h00b8);
    pv(16'h4000, 8'h20);
    pv(16'h4200, 8'h40);
    pv(16'h8000, 8'h41);
    wr(3, 16'h0000, 16'h00ff);
    chk(protection_reg_out, 8'hb8);
    background_debug_mode_in = 1'b1;
    wr(3, 16'h0000, 16'h00ff);
    background_debug_mode_in = 1'b0;
    chk(protection_reg_out, 8'hff);
  endtask
  task automatic t_sector;
    seq(16'h43fe, 16'h5555, 8'h40);
    wt(1'b1, 20);
    chk(arr_op_out, 2'h2);
    chk(arr_addr_out, 16'h4000);
    wt(1'b0, 5000);
    rd(16'h4002, 16'hffff);
    rd(16'h4400, 16'h00f0);
  endtask
  task automatic t_stop;
    seq(16'h4800, 16'h0000, 8'h40);
    wt(1'b1, 20);
    seq(16'h4802, 16'h0000, 8'h20);
    stop_mode_in = 1'b1;
    repeat (3) step;
    chk({arr_op_out, hv_en_out}, 3'h0);
    chk(command_complete_flag_out, 1'b1);
    chk(access_error_flag_out, 1'b1);
    stop_mode_in = 1'b0;
    repeat (3) step;
    chk(buffer_empty_flag_out, 1'b1);
    wr(2, 16'h0000, 16'h0030);
    rd(16'h4802, 16'hffff);
  endtask
  task automatic t_verify;
    seq(16'h9000, 16'h1111, 8'h05);
    wt(1'b0, 1000);
    chk(blank_flag_out, 1'b0);
    seq(16'h4000, 16'h0000, 8'h41);
    wt(1'b0, 25000);
    rd(16'h4400, 16'hffff);
    seq(16'h9000, 16'h1111, 8'h05);
    wt(1'b0, 30000);
    chk(blank_flag_out, 1'b1);
  endtask
  // Erased security byte must come back secured
  task automatic t_secure;
    do_reset;
    chk(secure_out, 1'b1);
    wr(4, 16'h0000, 16'h0000);
    nonsecure_src_in = 1'b1;
    bad(1'b0, 1, 16'h0020);
    nonsecure_src_in = 1'b0;
    background_debug_mode_in = 1'b1;
    bad(1'b0, 1, 16'h0020);
    seq(16'h4000, 16'h0000, 8'h41);
    chk(access_error_flag_out, 1'b0);
    chk(command_complete_flag_out, 1'b0);
    background_debug_mode_in = 1'b0;
  endtask
  initial begin
    n_fail = 0;
    n_checks = 0;
    {arr_wr_in, arr_wr_byte_in, clkdiv_wr_in, cmd_wr_in} = 4'h0;
    {stat_wr_in, prot_wr_in, other_reg_wr_in, stop_mode_in} = 4'h0;
    {buffer_empty_int_en_in, complete_int_en_in} = 2'h0;
    {background_debug_mode_in, nonsecure_src_in} = 2'h0;
    {arr_wr_addr_in, arr_wr_data_in, arr_rd_addr_in} = 48'h0;
    {clkdiv_data_in, cmd_data_in, stat_data_in, prot_data_in} = 31'h0;
    do_reset;
    t_reset;
    t_program;
    t_errors;
    t_protect;
    t_sector;
    t_stop;
    t_verify;
    t_secure;
    results;
  end
endmodule
